// file: rtl/pcs_pkg.sv
// Constants, register map and carrier types of the program counter sequencer
package pcs_pkg;
	localparam int PC_WIDTH = 13;
	localparam int WORD_WIDTH = 16;
	localparam int PHASES = 4;
	localparam int STACK_DEPTH = 16;
	localparam int IRQ_COUNT = 6;
	localparam int SST_CYCLES = 1024;
	localparam logic [PC_WIDTH-1:0] RESET_VECTOR = 13'h0000;
	// Interrupt vectors, lowest address first, so index order is priority order
	localparam logic [PC_WIDTH-1:0] IRQ_VECTOR [IRQ_COUNT] = '{
		13'h0004, 13'h0008, 13'h000C, 13'h0010, 13'h0014, 13'h0018};
	// Source bit positions in status and mask registers
	localparam int IRQ_EXT_A = 0;
	localparam int IRQ_EXT_B = 1;
	localparam int IRQ_TMR0 = 2;
	localparam int IRQ_TMR1 = 3;
	localparam int IRQ_TBASE = 4;
	localparam int IRQ_RTC = 5;
	// Avalon register byte offsets
	localparam int ADDR_WIDTH = 8;
	localparam logic [ADDR_WIDTH-1:0] REG_PCL = 8'h00;
	localparam logic [ADDR_WIDTH-1:0] REG_PC = 8'h04;
	localparam logic [ADDR_WIDTH-1:0] REG_IRQ_STATUS = 8'h08;
	localparam logic [ADDR_WIDTH-1:0] REG_IRQ_MASK = 8'h0C;
	localparam logic [ADDR_WIDTH-1:0] REG_CTRL = 8'h10;
	localparam logic [ADDR_WIDTH-1:0] REG_STACK = 8'h14;
	localparam int CTRL_GIE_BIT = 0;
	localparam logic [IRQ_COUNT-1:0] IRQ_MASK_RESET = 6'h00;
	localparam logic CTRL_GIE_RESET = 1'b0;

	// Flow operation reported by the decoder for the executing word
	typedef enum logic [2:0] {
		FLOW_NONE,
		FLOW_SKIP,
		FLOW_JUMP,
		FLOW_CALL,
		FLOW_RET,
		FLOW_RETI,
		FLOW_PCL,
		FLOW_HALT
	} pcs_flow_op_type;

	typedef struct packed {
		pcs_flow_op_type op;
		logic cond;
		logic [PC_WIDTH-1:0] target;
	} pcs_flow_type;

	typedef struct packed {
		logic read;
		logic write;
		logic [ADDR_WIDTH-1:0] address;
		logic [31:0] writedata;
		logic [3:0] byteenable;
	} pcs_avm_req_type;

	typedef struct packed {
		logic ext_a;
		logic ext_b;
		logic tmr0_ovf;
		logic tmr1_ovf;
		logic tbase;
		logic rtc;
	} pcs_events_type;
endpackage : pcs_pkg

// file: rtl/pcs_sequencer.sv
// Program counter sequencer: fetch/execute pipeline, stack, vectors, registers
//
// The Avalon-MM register port and the register offsets were decided locally.
`timescale 1ns/10ps
module pcs_sequencer
	import pcs_pkg::*;
#(
	parameter int SST_COUNT = SST_CYCLES
) (
	input wire logic i_mclk,
	input wire logic i_resetn,
	input wire logic i_ext_irq_a,
	input wire logic i_ext_irq_b,
	input wire logic i_tmr0_ovf,
	input wire logic i_tmr1_ovf,
	input wire logic i_tbase,
	input wire logic i_rtc,
	input wire logic [WORD_WIDTH-1:0] i_pm_data,
	input wire pcs_flow_type i_flow,
	input wire pcs_avm_req_type i_avm,
	output logic [PC_WIDTH-1:0] o_pm_addr,
	output logic [1:0] o_phase,
	output logic [WORD_WIDTH-1:0] o_exec_word,
	output logic o_exec_valid,
	output logic o_running,
	output logic o_irq,
	output logic o_waitrequest,
	output logic [31:0] o_readdata
);
	if (SST_COUNT < 2 || SST_COUNT > 65535) begin : g_sst_range
		$error("SST_COUNT out of range");
	end

	typedef enum logic [1:0] {
		ST_STARTUP,
		ST_RUN,
		ST_HALT
	} pcs_state_type;

	pcs_state_type state;
	logic [15:0] sst_cnt;
	logic [1:0] phase;
	logic [PC_WIDTH-1:0] pc;
	logic [WORD_WIDTH-1:0] exec_word;
	logic exec_valid;
	logic [PC_WIDTH-1:0] stack_mem [STACK_DEPTH];
	logic [3:0] return_stack_index;
	logic [4:0] stack_count;
	logic [IRQ_COUNT-1:0] irq_status;
	logic [IRQ_COUNT-1:0] irq_mask;
	logic gie;
	logic pcl_pend;
	logic [7:0] pcl_data;
	logic [1:0] sync_a;
	logic [1:0] sync_b;
	logic prev_a;
	logic prev_b;
	logic [IRQ_COUNT-1:0] events;
	logic boundary;
	logic stack_full;
	logic [PC_WIDTH-1:0] stack_top;
	logic [PC_WIDTH-1:0] next_pc;
	logic flush;
	logic push;
	logic pop;
	logic take_irq;
	logic halt_req;
	logic gie_set;
	logic [IRQ_COUNT-1:0] pending;
	logic [IRQ_COUNT-1:0] ack_bit;
	logic [2:0] irq_sel;
	logic irq_any;
	logic bus_acc;
	logic bus_wr;

	assign o_pm_addr = pc;
	assign o_phase = phase;
	assign o_exec_word = exec_word;
	assign o_exec_valid = exec_valid;
	assign boundary = (state == ST_RUN) && (phase == 2'(PHASES - 1));
	assign stack_full = (stack_count == 5'(STACK_DEPTH));
	assign stack_top = stack_mem[4'(return_stack_index - 4'h1)];
	assign bus_acc = (i_avm.read || i_avm.write) && !o_waitrequest;
	assign bus_wr = bus_acc && i_avm.write && i_avm.byteenable[0];

	////////////////////////////////////////////////////////////////////////////
	// Pin synchronisers, then rising edge detect on the settled copy
	always_ff @(posedge i_mclk) begin
		if (!i_resetn) begin
			sync_a <= 2'h0;
			sync_b <= 2'h0;
			prev_a <= 1'b0;
			prev_b <= 1'b0;
		end else begin
			sync_a <= {sync_a[0], i_ext_irq_a};
			sync_b <= {sync_b[0], i_ext_irq_b};
			prev_a <= sync_a[1];
			prev_b <= sync_b[1];
		end
	end

	// Event vector in priority order
	always_comb begin
		events = '0;
		events[IRQ_EXT_A] = sync_a[1] && !prev_a;
		events[IRQ_EXT_B] = sync_b[1] && !prev_b;
		events[IRQ_TMR0] = i_tmr0_ovf;
		events[IRQ_TMR1] = i_tmr1_ovf;
		events[IRQ_TBASE] = i_tbase;
		events[IRQ_RTC] = i_rtc;
	end

	always_comb begin
		pending = irq_status & irq_mask;
		irq_sel = 3'h0;
		irq_any = 1'b0;
		for (int i = IRQ_COUNT - 1; i >= 0; i--) begin
			if (pending[i]) begin
				irq_sel = 3'(i);
				irq_any = 1'b1;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Next counter value decided at the last phase of each cycle
	always_comb begin
		next_pc = PC_WIDTH'(pc + 13'h0001);
		flush = 1'b0;
		push = 1'b0;
		pop = 1'b0;
		take_irq = 1'b0;
		halt_req = 1'b0;
		gie_set = 1'b0;
		if (exec_valid) begin
			unique case (i_flow.op)
				FLOW_NONE: begin
				end
				FLOW_SKIP: begin
					flush = i_flow.cond;
				end
				FLOW_JUMP: begin
					next_pc = i_flow.target;
					flush = 1'b1;
				end
				FLOW_CALL: begin
					next_pc = i_flow.target;
					push = 1'b1;
					flush = 1'b1;
				end
				FLOW_RET, FLOW_RETI: begin
					next_pc = stack_top;
					pop = 1'b1;
					flush = 1'b1;
					gie_set = (i_flow.op == FLOW_RETI);
				end
				FLOW_PCL: begin
					next_pc = {pc[PC_WIDTH-1:8], i_flow.target[7:0]};
					flush = 1'b1;
				end
				FLOW_HALT: begin
					halt_req = 1'b1;
					next_pc = pc; // Prefetched word is fetched again after wake
				end
			endcase
		end
		if (!flush && !halt_req && pcl_pend) begin
			next_pc = {pc[PC_WIDTH-1:8], pcl_data};
			flush = 1'b1;
		end
		if (!flush && !halt_req && gie && irq_any && !stack_full) begin
			next_pc = IRQ_VECTOR[irq_sel];
			push = 1'b1;
			flush = 1'b1;
			take_irq = 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Run state and start-up hold
	always_ff @(posedge i_mclk) begin
		if (!i_resetn) begin
			state <= ST_STARTUP;
			sst_cnt <= 16'(SST_COUNT);
			o_running <= 1'b0;
		end else begin
			unique case (state)
				ST_STARTUP: begin
					sst_cnt <= 16'(sst_cnt - 16'h0001);
					if (sst_cnt == 16'h0001) begin
						state <= ST_RUN;
						o_running <= 1'b1;
					end
				end
				ST_RUN: begin
					if (boundary && halt_req) begin
						state <= ST_HALT;
						o_running <= 1'b0;
					end
				end
				// Any unmasked request wakes, then the full hold again
				ST_HALT: begin
					if (|pending) begin
						state <= ST_STARTUP;
						sst_cnt <= 16'(SST_COUNT);
					end
				end
			endcase
		end
	end

	// four phases per instruction cycle; parked at zero outside run
	always_ff @(posedge i_mclk) begin
		phase <= (!i_resetn || state != ST_RUN) ? 2'h0 : 2'(phase + 2'h1);
	end

	////////////////////////////////////////////////////////////////////////////
	// fetch and execute overlap
	always_ff @(posedge i_mclk) begin
		if (!i_resetn) begin
			pc <= RESET_VECTOR;
			exec_word <= 16'h0000;
			exec_valid <= 1'b0;
		end else if (state != ST_RUN) begin
			exec_valid <= 1'b0;
		end else if (boundary) begin
			pc <= next_pc;
			exec_word <= i_pm_data;
			// flushed slot becomes a dummy cycle
			exec_valid <= !flush && !halt_req;
		end
	end

	always_ff @(posedge i_mclk) begin
		if (!i_resetn) begin
			return_stack_index <= 4'h0;
			stack_count <= 5'h00;
		end else if (boundary && push) begin
			stack_mem[return_stack_index] <= pc;
			return_stack_index <= 4'(return_stack_index + 4'h1);
			if (!stack_full) begin
				stack_count <= 5'(stack_count + 5'h01);
			end
		end else if (boundary && pop && stack_count != 5'h00) begin
			return_stack_index <= 4'(return_stack_index - 4'h1);
			stack_count <= 5'(stack_count - 5'h01);
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Sticky request flags; a new event beats both clears
	assign ack_bit = ({IRQ_COUNT{boundary && take_irq}} & (IRQ_COUNT'(1) << irq_sel))
		| ({IRQ_COUNT{bus_wr && i_avm.address == REG_IRQ_STATUS}}
		& i_avm.writedata[IRQ_COUNT-1:0]);
	always_ff @(posedge i_mclk) begin
		if (!i_resetn) begin
			irq_status <= '0;
		end else begin
			irq_status <= (irq_status & ~ack_bit) | events;
		end
	end

	// Mask, global enable, pending low byte write
	always_ff @(posedge i_mclk) begin
		if (!i_resetn) begin
			irq_mask <= IRQ_MASK_RESET;
			gie <= CTRL_GIE_RESET;
			pcl_pend <= 1'b0;
			pcl_data <= 8'h00;
		end else begin
			if (bus_wr && i_avm.address == REG_IRQ_MASK) begin
				irq_mask <= i_avm.writedata[IRQ_COUNT-1:0];
			end
			// Acknowledge closes the gate until the handler returns
			if (boundary && take_irq) begin
				gie <= 1'b0;
			end else if (boundary && gie_set) begin
				gie <= 1'b1;
			end else if (bus_wr && i_avm.address == REG_CTRL) begin
				gie <= i_avm.writedata[CTRL_GIE_BIT];
			end
			// software short jump waits for the cycle boundary
			if (bus_wr && i_avm.address == REG_PCL) begin
				pcl_pend <= 1'b1;
				pcl_data <= i_avm.writedata[7:0];
			end else if (boundary && flush && (!exec_valid || i_flow.op == FLOW_NONE
				|| (i_flow.op == FLOW_SKIP && !i_flow.cond))) begin
				pcl_pend <= 1'b0;
			end
		end
	end

	// Level interrupt from unmasked flags, one clock behind them
	always_ff @(posedge i_mclk) begin
		o_irq <= i_resetn && (|pending);
	end

	////////////////////////////////////////////////////////////////////////////
	// Avalon slave: one wait cycle, then accept; unmapped reads as zero
	always_ff @(posedge i_mclk) begin
		if (!i_resetn) begin
			o_waitrequest <= 1'b1;
			o_readdata <= 32'h00000000;
		end else if (!o_waitrequest) begin
			o_waitrequest <= 1'b1;
		end else if (i_avm.read || i_avm.write) begin
			o_waitrequest <= 1'b0;
			o_readdata <= 32'h00000000;
			if (i_avm.read) begin
				unique case (i_avm.address)
					REG_PCL: o_readdata[7:0] <= pc[7:0];
					REG_PC: o_readdata[PC_WIDTH-1:0] <= pc;
					REG_IRQ_STATUS: o_readdata[IRQ_COUNT-1:0] <= irq_status;
					REG_IRQ_MASK: o_readdata[IRQ_COUNT-1:0] <= irq_mask;
					REG_CTRL: o_readdata[CTRL_GIE_BIT] <= gie;
					REG_STACK: o_readdata[4:0] <= stack_count;
					default: o_readdata <= 32'h00000000;
				endcase
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Checks
	default clocking cb @(posedge i_mclk);
	endclocking
	default disable iff (!i_resetn);

	sequence s_boundary;
		state == ST_RUN && phase == 2'h3;
	endsequence

	sequence s_plain_step;
		s_boundary ##0 (!flush && !halt_req);
	endsequence

	a_phase_wrap: assert property (s_boundary ##0 !halt_req |=> phase == 2'h0 ##1 phase == 2'h1)
		else $error("phase did not wrap after four clocks");
	a_pc_advance: assert property (s_plain_step |=> pc == 13'($past(pc) + 13'h0001))
		else $error("counter did not advance by one");
	a_prefetch_used: assert property (s_plain_step |=> exec_valid
		&& exec_word == $past(i_pm_data))
		else $error("prefetched word not executed");
	a_flush_dummy: assert property (s_boundary ##0 flush |=> !exec_valid [*4])
		else $error("flush did not give a dummy cycle");
	a_skip_two: assert property (s_boundary ##0 (exec_valid && i_flow.op == FLOW_SKIP
		&& i_flow.cond && !take_irq && !pcl_pend) |=> pc == 13'($past(pc) + 13'h0001))
		else $error("skip did not land two words on");
	a_jump_load: assert property (s_boundary ##0 (exec_valid && i_flow.op == FLOW_JUMP)
		|=> pc == $past(i_flow.target))
		else $error("jump target not loaded");
	a_pcl_page: assert property (s_boundary ##0 (exec_valid && i_flow.op == FLOW_PCL)
		|=> pc[12:8] == $past(pc[12:8]) && pc[7:0] == $past(i_flow.target[7:0]))
		else $error("low byte jump left the page");
	a_vector_addr: assert property (s_boundary ##0 take_irq
		|=> pc == IRQ_VECTOR[$past(irq_sel)] && !gie)
		else $error("wrong interrupt vector");
	a_full_withhold: assert property (s_boundary ##0 (stack_full && gie && irq_any && exec_valid
		&& i_flow.op == FLOW_NONE && !pcl_pend) |=> exec_valid)
		else $error("vectored with a full stack");
	a_lowest_first: assert property (take_irq |-> (pending & ((6'h01 << irq_sel) - 6'h01))
		== 6'h00)
		else $error("higher vector served first");
	a_startup_hold: assert property ($rose(state == ST_STARTUP) |-> !o_running
		throughout (state == ST_STARTUP) [*8])
		else $error("execution during start-up hold");
	a_stack_bound: assert property (stack_count <= 5'(STACK_DEPTH))
		else $error("stack count beyond depth");
endmodule : pcs_sequencer

// file: tb/pcs_pmem_model.sv
// Program memory model: each word is derived from its own address
`timescale 1ns/10ps
module pcs_pmem_model
	import pcs_pkg::*;
#(
	parameter bit REGISTERED = 1'b1
) (
	input wire logic i_mclk,
	input wire logic [PC_WIDTH-1:0] i_addr,
	output logic [WORD_WIDTH-1:0] o_data
);
	logic [WORD_WIDTH-1:0] q;
	// Slow variant lags one clock; the fetch address holds four clocks
	always_ff @(posedge i_mclk) begin
		q <= {3'h5, i_addr};
	end
	// Content pattern lets the bench predict every fetched word
	assign o_data = REGISTERED ? q : {3'h5, i_addr};
endmodule : pcs_pmem_model

// file: tb/tb_pcs_sequencer.sv
// Self-checking testbench of the program counter sequencer
`timescale 1ns/10ps
module tb_pcs_sequencer
	import pcs_pkg::*;
;
	localparam int SST = 8;
	localparam logic [12:0] VEC [6] = '{13'h0004, 13'h0008, 13'h000C, 13'h0010, 13'h0014, 13'h0018};
	logic i_mclk;
	logic i_resetn;
	logic [5:0] ev;
	pcs_flow_type flow;
	pcs_avm_req_type avm;
	logic [PC_WIDTH-1:0] pc;
	logic [PC_WIDTH-1:0] prev;
	logic [WORD_WIDTH-1:0] pm_data;
	logic [WORD_WIDTH-1:0] exec_word;
	logic [1:0] phase;
	logic exec_valid;
	logic running;
	logic irq;
	logic waitreq;
	logic [31:0] rdata;
	logic [31:0] rd;
	int err_total = 0;
	int check_count = 0;
	int cyc = 0;

	pcs_sequencer #(.SST_COUNT(SST)) dut (
		.i_mclk(i_mclk), .i_resetn(i_resetn), .i_ext_irq_a(ev[0]), .i_ext_irq_b(ev[1]),
		.i_tmr0_ovf(ev[2]), .i_tmr1_ovf(ev[3]), .i_tbase(ev[4]), .i_rtc(ev[5]),
		.i_pm_data(pm_data), .i_flow(flow), .i_avm(avm), .o_pm_addr(pc), .o_phase(phase),
		.o_exec_word(exec_word), .o_exec_valid(exec_valid), .o_running(running),
		.o_irq(irq), .o_waitrequest(waitreq), .o_readdata(rdata)
	);
	pcs_pmem_model u_pmem (.i_mclk(i_mclk), .i_addr(pc), .o_data(pm_data));

	////////////////////////////////////////////////////////////////////////////
	// Clock and hang guard
	initial begin
		i_mclk = 1'b0;
		forever #10 i_mclk = ~i_mclk;
	end
	// Whole run is a few hundred cycles; this cuts a hang short
	always @(posedge i_mclk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			err_total++;
			report_and_stop();
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Shared tasks
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			err_total++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : chk

	task automatic report_and_stop();
		$display("checks %0d errors %0d", check_count, err_total);
		if (err_total == 0 && check_count > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask : report_and_stop

	// Request held until the edge that sees waitrequest low
	task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge i_mclk);
		avm <= '{~wr, wr, a, d, 4'hF};
		do begin
			@(posedge i_mclk);
			n++;
		end while (waitreq !== 1'b0 && n < 20);
		rd = rdata;
		avm <= '{1'b0, 1'b0, 8'h00, 32'h0, 4'h0};
		chk(32'(n < 20), 32'h1);
	endtask : bus

	task automatic to_phase2();
		int n;
		n = 0;
		do begin
			@(posedge i_mclk);
			#1;
			n++;
		end while (!(phase === 2'h2 && exec_valid === 1'b1) && n < 40);
		prev = pc;
	endtask : to_phase2

	// Decoder verdict stands over the phase 3 edge only
	task automatic instr(input pcs_flow_op_type op, input logic c, input logic [12:0] t);
		to_phase2();
		@(posedge i_mclk);
		flow <= '{op, c, t};
		@(posedge i_mclk);
		flow <= '{FLOW_NONE, 1'b0, 13'h0000};
		#1;
	endtask : instr

	task automatic wait_pc(input logic [12:0] v);
		int n;
		n = 0;
		while (pc !== v && n < 24) begin
			@(posedge i_mclk);
			#1;
			n++;
		end
		chk(32'(pc), 32'(v));
	endtask : wait_pc

	task automatic pulse(input logic [5:0] m);
		@(posedge i_mclk);
		ev <= m;
		@(posedge i_mclk);
		ev <= 6'h00;
	endtask : pulse

	////////////////////////////////////////////////////////////////////////////
	// Scenarios
	task automatic t_reset();
		int n;
		logic [1:0] p;
		n = 0;
		repeat (3) @(posedge i_mclk);
		i_resetn <= 1'b1;
		#1;
		chk(32'(pc), 32'h0);
		chk(32'({running, waitreq}), 32'h1);
		do begin
			@(posedge i_mclk);
			#1;
			n++;
		end while (running !== 1'b1 && n < 50);
		chk(32'(n), 32'(SST));
		for (int i = 0; i < 8; i++) begin
			p = phase + 2'h1;
			@(posedge i_mclk);
			#1;
			chk(32'(phase), 32'(p));
		end
	endtask : t_reset

	task automatic t_seq();
		instr(FLOW_NONE, 1'b0, 13'h0000);
		chk(32'(pc), 32'(prev) + 1);
		chk(32'(exec_word), {16'h0, 3'h5, prev});
		instr(FLOW_JUMP, 1'b0, 13'h1FFE);
		chk(32'({exec_valid, pc}), 32'h1FFE);
		instr(FLOW_NONE, 1'b0, 13'h0000);
		chk(32'(pc), 32'h0);
	endtask : t_seq

	task automatic t_skip();
		instr(FLOW_SKIP, 1'b0, 13'h0000);
		chk(32'(exec_valid), 32'h1);
		instr(FLOW_SKIP, 1'b1, 13'h0000);
		chk(32'({exec_valid, pc}), 32'(prev) + 1);
		to_phase2();
		chk(32'(exec_word), {16'h0, 3'h5, prev - 13'h0001});
	endtask : t_skip

	task automatic t_call_pcl();
		logic [12:0] ret_a;
		instr(FLOW_CALL, 1'b0, 13'h0ABC);
		ret_a = prev;
		chk(32'(pc), 32'h0ABC);
		bus(1'b0, REG_STACK, 32'h0);
		chk(rd, 32'h1);
		instr(FLOW_RET, 1'b0, 13'h0000);
		chk(32'(pc), 32'(ret_a));
		instr(FLOW_JUMP, 1'b0, 13'h1300);
		bus(1'b1, REG_PCL, 32'h55);
		wait_pc(13'h1355);
		bus(1'b0, REG_PCL, 32'h0);
		chk(rd, 32'h55);
		bus(1'b0, 8'h3C, 32'h0);
		chk(rd, 32'h0);
	endtask : t_call_pcl

	task automatic t_irq();
		bus(1'b1, REG_IRQ_MASK, 32'h3F);
		pulse(6'h18);
		bus(1'b0, REG_IRQ_STATUS, 32'h0);
		chk(rd, 32'h18);
		chk(32'(irq), 32'h1);
		bus(1'b1, REG_IRQ_MASK, 32'h0);
		repeat (2) @(posedge i_mclk);
		#1;
		chk(32'(irq), 32'h0);
		bus(1'b1, REG_IRQ_MASK, 32'h3F);
		bus(1'b1, REG_CTRL, 32'h1);
		wait_pc(VEC[3]);
		instr(FLOW_RETI, 1'b0, 13'h0000);
		wait_pc(VEC[4]);
		instr(FLOW_RETI, 1'b0, 13'h0000);
		// Every source alone reaches its own vector
		for (int i = 0; i < 6; i++) begin
			pulse(6'h01 << i);
			wait_pc(VEC[i]);
			instr(FLOW_RETI, 1'b0, 13'h0000);
		end
		bus(1'b0, REG_IRQ_STATUS, 32'h0);
		chk(rd, 32'h0);
	endtask : t_irq

	// Halt parks the pipeline; a request wakes it through a fresh hold
	task automatic t_halt();
		logic [12:0] nxt;
		instr(FLOW_HALT, 1'b0, 13'h0000);
		nxt = prev;
		chk(32'({running, exec_valid, pc}), 32'(nxt));
		repeat (12) @(posedge i_mclk);
		#1;
		chk(32'({running, phase, pc}), 32'(nxt));
		pulse(6'h04);
		wait_pc(VEC[2]);
		instr(FLOW_RETI, 1'b0, 13'h0000);
		to_phase2();
		chk(32'(exec_word), {16'h0, 3'h5, nxt});
	endtask : t_halt

	task automatic t_full();
		// One call past the depth drops the oldest entry
		for (int i = 0; i < 17; i++) begin
			instr(FLOW_CALL, 1'b0, 13'h0200);
		end
		bus(1'b0, REG_STACK, 32'h0);
		chk(rd, 32'h10);
		pulse(6'h20);
		repeat (3) instr(FLOW_NONE, 1'b0, 13'h0000);
		chk(32'(pc), 32'(prev) + 1);
		bus(1'b0, REG_IRQ_STATUS, 32'h0);
		chk(rd, 32'h20);
		instr(FLOW_RET, 1'b0, 13'h0000);
		wait_pc(VEC[5]);
	endtask : t_full

	////////////////////////////////////////////////////////////////////////////
	// Main sequence
	initial begin
		i_resetn = 1'b0;
		ev = 6'h00;
		flow = '{FLOW_NONE, 1'b0, 13'h0000};
		avm = '{1'b0, 1'b0, 8'h00, 32'h0, 4'h0};
		t_reset();
		t_seq();
		t_skip();
		t_call_pcl();
		t_irq();
		t_halt();
		t_full();
		report_and_stop();
	end
endmodule : tb_pcs_sequencer
